// ==== design/cansr_status.v ====
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "cansr_regs.vh"

module cansr_status (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        clkEn,
   // APB slave port.
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Protocol engine, same clock domain.
   input  wire        bitStrobe,
   input  wire        nodeDriving,
   input  wire        inArbitration,
   input  wire        txBit,
   input  wire        rxBit,
   input  wire        recoveryActive,
   input  wire        missingAckPulse,
   input  wire        crcMismatchPulse,
   input  wire        stuffErrorPulse,
   input  wire        formErrorPulse,
   input  wire        txDonePulse,
   input  wire        rxDonePulse,
   input  wire        errorPassiveIn,
   input  wire        busOffIn,
   input  wire [7:0]  txErrCount,
   input  wire [6:0]  rxErrCount,
   // Interrupt line, high while the status interrupt is pending.
   output reg         statusIrq
);

   // The block keeps the software-visible status word of the controller.
   // Event pulses from the protocol engine arrive on core_clk, already
   // aligned, so none of them passes a synchroniser here.
   // Every stored bit moves only while clkEn is high; with clkEn low the
   // bus handshake stalls as well, so a master just sees a longer access.
   // A pulse that arrives while clkEn is low is lost, which is why the
   // engine must share the enable with this block.
   // Software and hardware may touch the last-error field in one cycle.
   // The hardware value is kept, because a lost bus event cannot be
   // recovered while a lost write can simply be repeated.

   // Status register fields.
   reg  [2:0]  lastErrorCode_reg;   // Last-error field.
   reg  [2:0]  lastErrorCode_next;  // Next value of the last-error field.
   reg         txSuccess_reg;       // Transmit-success flag.
   reg         txSuccess_next;      // Its next value.
   reg         rxSuccess_reg;       // Receive-success flag.
   reg         rxSuccess_next;      // Its next value.
   reg         errPassive_reg;      // Error-passive indicator.
   reg         errWarning_reg;      // Error-warning indicator.
   reg         busOff_reg;          // Bus-off indicator.

   // Control register: interrupt enables.
   reg         statusIrqEn_reg;     // Status-change interrupt enable.
   reg         errorIrqEn_reg;      // Error interrupt enable.

   // Pending status interrupt.
   reg         irqPending_reg;      // Status interrupt pending.
   reg         irqPending_next;     // Its next value.

   // Recessive run counter for bus-off recovery.
   reg  [3:0]  idleRun_reg;         // Consecutive recessive bits seen.
   reg  [3:0]  idleRun_next;        // Its next value.
   reg         idleRunDone;         // Run of recessive bits completed.

   // Hardware error event decode.
   reg         lecEvent;            // Hardware loads the error field.
   reg  [2:0]  lecEventCode;        // Code that hardware loads.

   // Bus access decode.
   wire        accessDone;          // Access completes at this edge.
   wire        wrDone;              // Write completes at this edge.
   wire        rdDone;              // Read completes at this edge.
   reg         selCtrl;             // Control register addressed.
   reg         selStatus;           // Status register addressed.
   reg         selErrCnt;           // Error counter register addressed.
   reg         selIrqId;            // Interrupt identifier addressed.
   reg         selNone;             // Unmapped address.
   reg  [31:0] readData;            // Read multiplexer output.

   // Derived levels and change detection.
   wire        warnNow;             // Any counter at or above the limit.
   reg         hwStatusChange;      // Success flag or code changed.
   reg         hwErrorChange;       // Bus-off or warning flag changed.

   // The access phase always takes one wait state so that pready
   // can come straight from a flip-flop.
   assign accessDone = psel & penable & pready;
   assign wrDone     = accessDone & pwrite;
   assign rdDone     = accessDone & ~pwrite;

   // The warning level compares both counters against the limit.
   // The receive counter is one bit narrower, so it is widened with a
   // zero before the compare.
   assign warnNow = (txErrCount >= `CANSR_WARN_LIMIT) ||
                    ({1'b0, rxErrCount} >= `CANSR_WARN_LIMIT);

   // Register map, one aligned word each.
   // Control sits at the base and holds the two interrupt enables.
   // Status sits one word above, with the error field, flags and states.
   // The error counters follow as read-only copies of the engine's.
   // The interrupt identifier shows the status value while it is pending.
   // Partial or misaligned addresses fall into the unmapped branch and
   // answer with an error, so a stray access never changes a register.
   // Address decode in priority order; only full word addresses hit.
   always @* begin
      selCtrl   = 1'b0;
      selStatus = 1'b0;
      selErrCnt = 1'b0;
      selIrqId  = 1'b0;
      selNone   = 1'b0;
      if (paddr == `CANSR_CTRL_ADDR) begin
         selCtrl = 1'b1;
      end else if (paddr == `CANSR_STATUS_ADDR) begin
         selStatus = 1'b1;
      end else if (paddr == `CANSR_ERRCNT_ADDR) begin
         selErrCnt = 1'b1;
      end else if (paddr == `CANSR_IRQID_ADDR) begin
         selIrqId = 1'b1;
      end else begin
         selNone = 1'b1;
      end
   end

   // Recessive run counting while bus-off recovery waits for idle.
   // Any dominant bit restarts the run, so a stuck bus never scores.
   // Four bits are enough, since the run never exceeds eleven bits.
   always @* begin
      idleRun_next = idleRun_reg;
      idleRunDone  = 1'b0;
      if (!recoveryActive) begin
         idleRun_next = 4'h0;
      end else if (bitStrobe) begin
         if (!rxBit) begin
            idleRun_next = 4'h0;
         end else if (idleRun_reg == (`CANSR_IDLE_RUN - 4'h1)) begin
            idleRun_next = 4'h0;
            idleRunDone  = 1'b1;
         end else begin
            idleRun_next = idleRun_reg + 4'h1;
         end
      end
   end

   // Error event decode.  Bit errors are seen at the sample strobe
   // and take precedence, since they end any frame at once.  Code 7
   // is never produced here.
   // Stuff and form errors come from the receive path and take the
   // lowest error priority; the success clear ranks below all of them.
   always @* begin
      lecEvent     = 1'b1;
      lecEventCode = `CANSR_LEC_NONE;
      if (bitStrobe && nodeDriving && !inArbitration &&
          txBit && !rxBit) begin
         lecEventCode = `CANSR_LEC_BIT1;
      end else if (bitStrobe && nodeDriving && !txBit && rxBit) begin
         lecEventCode = `CANSR_LEC_BIT0;
      end else if (idleRunDone) begin
         lecEventCode = `CANSR_LEC_BIT0;
      end else if (missingAckPulse) begin
         lecEventCode = `CANSR_LEC_ACK;
      end else if (crcMismatchPulse) begin
         lecEventCode = `CANSR_LEC_CRC;
      end else if (stuffErrorPulse) begin
         lecEventCode = `CANSR_LEC_STUFF;
      end else if (formErrorPulse) begin
         lecEventCode = `CANSR_LEC_FORM;
      end else if (txDonePulse || rxDonePulse) begin
         lecEventCode = `CANSR_LEC_NONE;
      end else begin
         lecEvent = 1'b0;
      end
   end

   // Next values of the software-writable fields.  A hardware event
   // in the same cycle as a software write wins, so no event is lost.
   always @* begin
      lastErrorCode_next = lastErrorCode_reg;
      txSuccess_next     = txSuccess_reg;
      rxSuccess_next     = rxSuccess_reg;
      if (wrDone && selStatus) begin
         lastErrorCode_next = pwdata[`CANSR_LEC_MSB:`CANSR_LEC_LSB];
         txSuccess_next     = pwdata[`CANSR_TX_SUCCESS_FLAG_BIT];
         rxSuccess_next     = pwdata[`CANSR_RX_SUCCESS_FLAG_BIT];
      end
      if (lecEvent) begin
         lastErrorCode_next = lecEventCode;
      end
      // Hardware only ever sets the flags, never clears them.
      if (txDonePulse) begin
         txSuccess_next = 1'b1;
      end
      if (rxDonePulse) begin
         rxSuccess_next = 1'b1;
      end
   end

   // Change detection counts only hardware-made changes, so software
   // writes and the passive indicator never raise anything.
   // Comparing with the stored copies instead of looking for edges means
   // that a level which moves while clkEn is low is still reported once
   // the enable returns.
   always @* begin
      hwStatusChange = (lecEvent && (lecEventCode != lastErrorCode_reg)) ||
                       (txDonePulse && !txSuccess_reg) ||
                       (rxDonePulse && !rxSuccess_reg);
      hwErrorChange  = (busOffIn != busOff_reg) ||
                       (warnNow != errWarning_reg);
   end

   // Pending status interrupt: set on an enabled change, cleared by a
   // status read; a set in the same cycle as the read wins.
   always @* begin
      irqPending_next = irqPending_reg;
      if (rdDone && selStatus) begin
         irqPending_next = 1'b0;
      end
      if ((hwStatusChange && statusIrqEn_reg) ||
          (hwErrorChange && errorIrqEn_reg)) begin
         irqPending_next = 1'b1;
      end
   end

   // Read multiplexer; reserved and unmapped bits read as zero.
   always @* begin
      readData = 32'h00000000;
      if (selCtrl) begin
         readData[`CANSR_SIE_BIT] = statusIrqEn_reg;
         readData[`CANSR_EIE_BIT] = errorIrqEn_reg;
      end else if (selStatus) begin
         readData[`CANSR_LEC_MSB:`CANSR_LEC_LSB] = lastErrorCode_reg;
         readData[`CANSR_TX_SUCCESS_FLAG_BIT]  = txSuccess_reg;
         readData[`CANSR_RX_SUCCESS_FLAG_BIT]  = rxSuccess_reg;
         readData[`CANSR_ERROR_PASSIVE_FLAG_BIT] = errPassive_reg;
         readData[`CANSR_ERROR_WARNING_FLAG_BIT] = errWarning_reg;
         readData[`CANSR_BUS_OFF_FLAG_BIT]  = busOff_reg;
      end else if (selErrCnt) begin
         readData[7:0]  = txErrCount;
         readData[14:8] = rxErrCount;
      end else if (selIrqId) begin
         readData[15:0] = irqPending_reg ? `CANSR_IRQ_STATUS
                                         : `CANSR_IRQ_NONE;
      end
   end

   // Bus handshake: pready rises one cycle into the access phase and
   // falls after the completing edge; data and error are loaded with it.
   // With clkEn high, every access therefore lasts exactly two cycles past setup.  The
   // fixed wait state costs one cycle per access, which is cheap next to
   // the timing gained by a registered ready.
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (clkEn) begin
         if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= selNone;
            prdata  <= pwrite ? 32'h00000000 : readData;
         end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   // Control register; only the two enable bits are stored.
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         {statusIrqEn_reg, errorIrqEn_reg} <= `CANSR_CTRL_RESET;
      end else if (clkEn) begin
         if (wrDone && selCtrl) begin
            statusIrqEn_reg <= pwdata[`CANSR_SIE_BIT];
            errorIrqEn_reg  <= pwdata[`CANSR_EIE_BIT];
         end
      end
   end

   // Status fields.  The three state indicators follow the engine one
   // cycle late and take no part in software writes.
   // Reserved bits above the indicators have no storage at all, so they
   // cannot keep a written value.
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lastErrorCode_reg <= `CANSR_LEC_RESET;
         txSuccess_reg     <= `CANSR_FLAG_RESET;
         rxSuccess_reg     <= `CANSR_FLAG_RESET;
         errPassive_reg    <= `CANSR_FLAG_RESET;
         errWarning_reg    <= `CANSR_FLAG_RESET;
         busOff_reg        <= `CANSR_FLAG_RESET;
      end else if (clkEn) begin
         lastErrorCode_reg <= lastErrorCode_next;
         txSuccess_reg     <= txSuccess_next;
         rxSuccess_reg     <= rxSuccess_next;
         errPassive_reg    <= errorPassiveIn;
         errWarning_reg    <= warnNow;
         busOff_reg        <= busOffIn;
      end
   end

   // Interrupt pending state, recovery counter and interrupt line.
   // The line copies the next pending value, so it rises in the same
   // cycle as the identifier and never lags behind it.
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irqPending_reg <= 1'b0;
         idleRun_reg    <= 4'h0;
         statusIrq      <= 1'b0;
      end else if (clkEn) begin
         irqPending_reg <= irqPending_next;
         idleRun_reg    <= idleRun_next;
         statusIrq      <= irqPending_next;
      end
   end

endmodule
`default_nettype wire

// ==== design/cansr_regs.vh ====
// Register map, field layout, codes and limits of the CAN status block.
`ifndef CANSR_REGS_VH
`define CANSR_REGS_VH

// Byte addresses of the registers on the APB.
`define CANSR_CTRL_ADDR    32'h40050000
`define CANSR_STATUS_ADDR  32'h40050004
`define CANSR_ERRCNT_ADDR  32'h40050008
`define CANSR_IRQID_ADDR   32'h40050010

// Field positions inside the status register.
`define CANSR_LEC_MSB      2
`define CANSR_LEC_LSB      0
`define CANSR_TX_SUCCESS_FLAG_BIT     3
`define CANSR_RX_SUCCESS_FLAG_BIT     4
`define CANSR_ERROR_PASSIVE_FLAG_BIT    5
`define CANSR_ERROR_WARNING_FLAG_BIT    6
`define CANSR_BUS_OFF_FLAG_BIT     7

// Field positions inside the control register.
`define CANSR_SIE_BIT      2
`define CANSR_EIE_BIT      3

// Last-error codes.
`define CANSR_LEC_NONE     3'h0
`define CANSR_LEC_STUFF    3'h1
`define CANSR_LEC_FORM     3'h2
`define CANSR_LEC_ACK      3'h3
`define CANSR_LEC_BIT1     3'h4
`define CANSR_LEC_BIT0     3'h5
`define CANSR_LEC_CRC      3'h6
`define CANSR_LEC_MARKER   3'h7

// Reset values.
`define CANSR_LEC_RESET    3'h0
`define CANSR_FLAG_RESET   1'h0
`define CANSR_CTRL_RESET   2'h0

// Limits and identifiers.
`define CANSR_WARN_LIMIT   8'h60
`define CANSR_IDLE_RUN     4'hB
`define CANSR_IRQ_STATUS   16'h8000
`define CANSR_IRQ_NONE     16'h0000

`endif

// ==== tb/cansr_status_props.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cansr_regs.vh"
// Watches the status block's APB port and status indicators.
module cansr_status_props (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        errorPassiveIn,
   input wire logic        busOffIn,
   input wire logic [7:0]  txErrCount,
   input wire logic [6:0]  rxErrCount
);
   // Only the four word addresses decode.
   wire logic mapped = paddr == `CANSR_CTRL_ADDR
      || paddr == `CANSR_STATUS_ADDR || paddr == `CANSR_ERRCNT_ADDR
      || paddr == `CANSR_IRQID_ADDR;
   wire logic stsRd = pready && !pwrite && paddr == `CANSR_STATUS_ADDR;
   wire logic idRd = pready && !pwrite && paddr == `CANSR_IRQID_ADDR;
   // Warning level; 96 is the limit on either counter.
   wire logic warn = txErrCount >= 8'h60 || rxErrCount >= 7'h60;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // A setup cycle followed by the first access cycle.
   sequence apbSetup;
      psel && !penable ##1 psel && penable;
   endsequence
   a_ready_timing: assert property (apbSetup |=> pready)
      else $error("pready not in second access cycle");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_decode_error: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr does not match decode");
   a_reserved_zero: assert property (
      stsRd |-> prdata[31:8] == 24'h0)
      else $error("reserved status bits not zero");
   // Inputs held for three cycles must show on the read word.
   a_busoff_shown: assert property (
      stsRd && $stable(busOffIn) && $past(busOffIn, 2) == busOffIn
      |-> prdata[7] == busOffIn) else $error("bus-off bit wrong");
   a_passive_shown: assert property (
      stsRd && $stable(errorPassiveIn)
      && $past(errorPassiveIn, 2) == errorPassiveIn
      |-> prdata[5] == errorPassiveIn) else $error("passive bit wrong");
   a_warning_shown: assert property (
      stsRd && $stable(warn) && $past(warn, 2) == warn
      |-> prdata[6] == warn) else $error("warning bit wrong");
   a_irqid_form: assert property (
      idRd |-> prdata == 32'h0 || prdata == 32'h8000)
      else $error("identifier value out of range");
endmodule
`default_nettype wire

// ==== tb/cansr_bus_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Stand-in for the protocol engine and the other nodes on the bus.
module cansr_bus_model (
   input  wire logic       core_clk,
   output var  logic       bitStrobe,
   output var  logic       nodeDriving,
   output var  logic       inArbitration,
   output var  logic       txBit,
   output var  logic       rxBit,
   output var  logic       recoveryActive,
   output var  logic       errorPassiveIn,
   output var  logic       busOffIn,
   output var  logic [7:0] txErrCount,
   output var  logic [6:0] rxErrCount,
   output var  logic [5:0] pv
);
   // Pulses: ack, crc, stuff, form, tx done, rx done.
   initial begin
      {bitStrobe, nodeDriving, inArbitration, txBit, rxBit} = 5'h0;
      {recoveryActive, errorPassiveIn, busOffIn} = 3'h0;
      {txErrCount, rxErrCount, pv} = 21'h0;
   end
   // One engine pulse lasting one cycle.
   task automatic pulse(input int k);
      @(posedge core_clk);
      pv <= 6'h01 << k;
      @(posedge core_clk);
      pv <= 6'h00;
   endtask
   // One sample point; stale bit levels are inverted afterwards.
   task automatic bitAt(input logic tx, rx, drv, arb);
      @(posedge core_clk);
      {bitStrobe, txBit, rxBit, nodeDriving, inArbitration} <=
         {1'b1, tx, rx, drv, arb};
      @(posedge core_clk);
      {bitStrobe, txBit, rxBit, nodeDriving, inArbitration} <=
         {1'b0, ~tx, ~rx, 2'h0};
   endtask
   // Faults 0..3 are pulses, 4 and 5 are bit mismatches.
   task automatic fault(input int k);
      if (k == 4) bitAt(1'b1, 1'b0, 1'b1, 1'b0);
      else if (k == 5) bitAt(1'b0, 1'b1, 1'b1, 1'b0);
      else pulse(k);
   endtask
   // Engine state levels, changed just after an edge.
   task automatic setLv(input logic rc, p, b, input logic [7:0] t,
                        input logic [6:0] r);
      @(posedge core_clk);
      {recoveryActive, errorPassiveIn, busOffIn} <= {rc, p, b};
      {txErrCount, rxErrCount} <= {t, r};
   endtask
endmodule
`default_nettype wire

// ==== tb/can_status_reporting_test.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cansr_regs.vh"
module can_status_reporting_test;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd, ST, CT, EC, IQ;
   logic        se, clkEn = 1'b1;
   wire  [31:0] prdata;
   wire         pready, pslverr, statusIrq, bS, nD, iA, tB, rB, rA, eP, bO;
   wire  [7:0]  tC;
   wire  [6:0]  rC;
   wire  [5:0]  pv;
   logic [2:0]  last_error_code [6] = '{3'h3, 3'h6, 3'h1, 3'h2, 3'h4, 3'h5};
   int          err_count = 0, total_checks = 0;
   assign {ST, CT} = {`CANSR_STATUS_ADDR, `CANSR_CTRL_ADDR};
   assign {EC, IQ} = {`CANSR_ERRCNT_ADDR, `CANSR_IRQID_ADDR};
   always #50 core_clk = ~core_clk;
   cansr_status uut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bitStrobe(bS), .nodeDriving(nD), .inArbitration(iA), .txBit(tB),
      .rxBit(rB), .recoveryActive(rA), .missingAckPulse(pv[0]),
      .crcMismatchPulse(pv[1]), .stuffErrorPulse(pv[2]),
      .formErrorPulse(pv[3]), .txDonePulse(pv[4]), .rxDonePulse(pv[5]),
      .errorPassiveIn(eP), .busOffIn(bO), .txErrCount(tC),
      .rxErrCount(rC), .statusIrq(statusIrq));
   cansr_bus_model bus (.core_clk(core_clk), .bitStrobe(bS),
      .nodeDriving(nD), .inArbitration(iA), .txBit(tB), .rxBit(rB),
      .recoveryActive(rA), .errorPassiveIn(eP), .busOffIn(bO),
      .txErrCount(tC), .rxErrCount(rC), .pv(pv));
   task automatic chk(input string what, input logic [31:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer, held until pready is sampled high.
   task automatic apb(input logic w, input logic [31:0] a, d);
      int n;
      n = 0;
      @(posedge core_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      {rd, se} = {prdata, pslverr};
      chk("pready", 32'h1, {31'h0, pready});
      {psel, penable} <= 2'h0;
   endtask
   task automatic rdchk(input string what, input logic [31:0] a, exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask
   task automatic ind(input logic p, b, input logic [7:0] t,
                      input logic [6:0] r, input logic [31:0] exp);
      bus.setLv(1'b0, p, b, t, r);
      rdchk("indicators", ST, exp);
      rdchk("counters", EC, {17'h0, r, t});
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Stops a hung run; the tests need well under a thousand cycles.
   initial begin
      #2000000;
      err_count++;
      finish_test;
   end
   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      rdchk("status", ST, 32'h0);
      rdchk("irqid", IQ, 32'h0);
      // A pulse while the clock enable is low must leave no trace.
      @(posedge core_clk) clkEn <= 1'b0;
      bus.fault(0);
      clkEn <= 1'b1;
      rdchk("frozen", ST, 32'h0);
      $display("reset test done");
      for (int k = 0; k < 6; k++) begin
         bus.fault(k);
         rdchk("code", ST, {29'h0, last_error_code[k]});
      end
      bus.bitAt(1'b1, 1'b0, 1'b1, 1'b1);
      rdchk("arbitration", ST, 32'h5);
      bus.pulse(4);
      rdchk("tx done", ST, 32'h8);
      bus.pulse(5);
      rdchk("rx done", ST, 32'h18);
      bus.fault(0);
      rdchk("flags kept", ST, 32'h1B);
      apb(1'b1, ST, 32'h7);
      rdchk("marker", ST, 32'h7);
      apb(1'b1, ST, 32'hFFFFFFFF);
      rdchk("read only", ST, 32'h1F);
      apb(1'b1, ST, 32'h0);
      bus.setLv(1'b1, 1'b0, 1'b0, 8'h0, 7'h0);
      repeat (10) bus.bitAt(1'b1, 1'b1, 1'b0, 1'b0);
      rdchk("ten idle", ST, 32'h0);
      bus.bitAt(1'b1, 1'b1, 1'b0, 1'b0);
      rdchk("eleven idle", ST, 32'h5);
      apb(1'b1, ST, 32'h0);
      $display("code test done");
      ind(1'b1, 1'b0, 8'h0, 7'h0, 32'h20);
      ind(1'b0, 1'b1, 8'h0, 7'h0, 32'h80);
      ind(1'b0, 1'b0, 8'h60, 7'h0, 32'h40);
      ind(1'b0, 1'b0, 8'h5F, 7'h5F, 32'h0);
      ind(1'b0, 1'b0, 8'h0, 7'h60, 32'h40);
      ind(1'b0, 1'b0, 8'h0, 7'h0, 32'h0);
      $display("indicator test done");
      apb(1'b1, CT, 32'h4);
      bus.fault(0);
      rdchk("irq set", IQ, 32'h8000);
      rdchk("status", ST, 32'h3);
      rdchk("irq clear", IQ, 32'h0);
      chk("irq line low", 32'h0, {31'h0, statusIrq});
      apb(1'b1, ST, 32'h0);
      apb(1'b1, CT, 32'hC);
      bus.setLv(1'b0, 1'b1, 1'b0, 8'h0, 7'h0);
      rdchk("no irq", IQ, 32'h0);
      apb(1'b1, CT, 32'h8);
      bus.fault(1);
      rdchk("masked", IQ, 32'h0);
      bus.setLv(1'b0, 1'b1, 1'b1, 8'h0, 7'h0);
      rdchk("error irq", IQ, 32'h8000);
      chk("irq line", 32'h1, {31'h0, statusIrq});
      rdchk("status", ST, 32'hA6);
      apb(1'b0, ST + 32'h100, 32'h0);
      chk("slverr", 32'h1, {31'h0, se});
      chk("unmapped data", 32'h0, rd);
      $display("interrupt test done");
      finish_test;
   end
endmodule
bind cansr_status cansr_status_props chk (.core_clk(core_clk),
   .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .errorPassiveIn(errorPassiveIn), .busOffIn(busOffIn),
   .txErrCount(txErrCount), .rxErrCount(rxErrCount));
`default_nettype wire
